// ==== logic/pmalt_core.sv ====
// link control, gating, status and transmit path of a four-pair ternary PHY attachment
// assumes link integrity, carrier sense and align logic sit outside on the same clock;
// receive pair symbols come from pins and are synchronised here
`timescale 1ns/1ps
`default_nettype none
`include "pmalt_params.svh"

module pmalt_core
  import pmalt_pkg::*;
#(
  parameter int unsigned SILENCE_CYCLES = `PMALT_SILENCE_US * `PMALT_CLK_KHZ / 1000,
  parameter int unsigned SILENCE_MIN    =
    ((`PMALT_SILENCE_US - `PMALT_SIL_TOL_US) * `PMALT_CLK_KHZ + 999) / 1000,
  parameter int unsigned SILENCE_MAX    =
    (`PMALT_SILENCE_US + `PMALT_SIL_TOL_US) * `PMALT_CLK_KHZ / 1000
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst_n,
  input  wire logic              i_clk_en,
  // register bus
  input  wire logic              i_hsel,
  input  wire logic [31:0]       i_haddr,
  input  wire logic [1:0]        i_htrans,
  input  wire logic              i_hwrite,
  input  wire logic [2:0]        i_hsize,
  input  wire logic [31:0]       i_hwdata,
  input  wire logic              i_hready,
  output logic      [31:0]       o_hrdata,
  output logic                   o_hreadyout,
  output logic                   o_hresp,
  // negotiator
  input  wire logic              i_link_req_valid,
  input  wire pmalt_link_ctrl_t  i_link_req,
  output pmalt_link_stat_t       o_link_status,
  // link integrity machine
  input  wire logic              i_li_pass,
  input  wire logic              i_li_pulses_seen,
  output logic                   o_li_hold_reset,
  output logic                   o_li_block_pass,
  output logic                   o_rcv_gate,
  output logic                   o_xmit_gate,
  output logic                   o_pma_reset,
  // client transmit
  input  wire logic              i_tx_data,
  input  wire pmalt_sym_t        i_tx_sym_pair,
  input  wire pmalt_sym_t        i_tx_sym_bi_a,
  input  wire pmalt_sym_t        i_tx_sym_bi_b,
  input  wire logic              i_pma_carrier,
  // client receive
  input  wire logic              i_rx_carrier,
  input  wire logic              i_rx_aligned,
  input  wire logic              i_rx_err_detect,
  output pmalt_rx_kind_t         o_rx_kind,
  output pmalt_sym_t             o_rx_sym_pair,
  output pmalt_sym_t             o_rx_sym_bi_a,
  output pmalt_sym_t             o_rx_sym_bi_b,
  output logic                   o_rx_error,
  // medium connector interface
  output pmalt_sym_t             o_transmit_only_pair,
  input  wire pmalt_sym_t        i_receive_only_pair,
  output pmalt_sym_t             o_bidirectional_pair_a,
  output logic                   o_bidirectional_pair_a_oe,
  input  wire pmalt_sym_t        i_bidirectional_pair_a,
  output pmalt_sym_t             o_bidirectional_pair_b,
  output logic                   o_bidirectional_pair_b_oe,
  input  wire pmalt_sym_t        i_bidirectional_pair_b
);

  localparam logic [`PMALT_CNT_W-1:0] SIL_RESET = `PMALT_CNT_W'(SILENCE_CYCLES);
  localparam logic [`PMALT_CNT_W-1:0] SIL_LO    = `PMALT_CNT_W'(SILENCE_MIN);
  localparam logic [`PMALT_CNT_W-1:0] SIL_HI    = `PMALT_CNT_W'(SILENCE_MAX);
  pmalt_state_t q;
  pmalt_state_t next_q;
  logic pma_reset;
  logic active;
  logic gate;
  logic eff_data;
  logic bus_acc;

  // ==========================================================================
  // helpers
  // keeps software from loading a silence outside the permitted window
  function automatic logic [`PMALT_CNT_W-1:0] clamp_sil(input logic [31:0] v);
    logic [`PMALT_CNT_W-1:0] r;
    if (v < 32'(SIL_LO)) begin
      r = SIL_LO;
    end else if (v > 32'(SIL_HI)) begin
      r = SIL_HI;
    end else begin
      r = v[`PMALT_CNT_W-1:0];
    end
    return r;
  endfunction : clamp_sil

  function automatic logic [31:0] read_reg(input logic [7:0] a, input pmalt_state_t s,
                                           input logic rst);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      `PMALT_ADDR_CTRL: r[`PMALT_CTRL_PDN] = s.power_down;
      `PMALT_ADDR_STAT: begin
        r[`PMALT_STAT_LINK +: 2] = s.link_stat;
        r[`PMALT_STAT_CTL +: 2]  = s.link_ctrl;
        r[`PMALT_STAT_RCV]       = s.rcv_gate;
        r[`PMALT_STAT_XMIT]      = s.xmit_gate;
        r[`PMALT_STAT_RST]       = rst;
        r[`PMALT_STAT_RXERR]     = s.rx_error;
        r[`PMALT_STAT_COLL]      = s.collided;
      end
      `PMALT_ADDR_IDLE: r[`PMALT_CNT_W-1:0] = s.sil_load;
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction : read_reg

  // ==========================================================================
  // gating
  assign pma_reset = (q.rst_cnt != 3'h0);
  assign active    = !pma_reset && !q.power_down;
  // one gate serves both directions: pass in enable only
  assign gate      = active && (q.link_ctrl == LC_ENABLE) && i_li_pass;
  assign eff_data  = i_tx_data && gate;
  assign bus_acc   = i_hsel && i_htrans[1] && i_hready;

  // ==========================================================================
  // next state
  always_comb begin
    next_q = q;
    // register bus, zero wait states
    if (q.rst_cnt != 3'h0) begin
      next_q.rst_cnt = q.rst_cnt - 3'h1;
    end
    next_q.wr_pend = bus_acc && i_hwrite;
    next_q.wr_addr = i_haddr[7:0];
    if (bus_acc && !i_hwrite) begin
      next_q.hrdata = read_reg(i_haddr[7:0], q, pma_reset);
    end
    if (q.wr_pend) begin
      unique case (q.wr_addr)
        `PMALT_ADDR_CTRL: begin
          next_q.power_down = i_hwdata[`PMALT_CTRL_PDN];
          if (i_hwdata[`PMALT_CTRL_SRST]) begin
            next_q.rst_cnt = `PMALT_RST_CYCLES;
          end
        end
        `PMALT_ADDR_IDLE: next_q.sil_load = clamp_sil(i_hwdata);
        default: next_q.wr_pend = next_q.wr_pend;
      endcase
    end

    // link control, only the three legal codes are taken
    if (i_link_req_valid && active
        && (i_link_req inside {LC_SCAN, LC_DISABLE, LC_ENABLE})) begin
      next_q.link_ctrl = i_link_req;
    end
    unique case (q.link_ctrl)
      LC_SCAN:    next_q.link_stat = i_li_pulses_seen ? LS_READY : LS_FAIL;
      LC_DISABLE: next_q.link_stat = LS_FAIL;
      default:    next_q.link_stat = i_li_pass ? LS_OK : LS_FAIL;
    endcase
    if (!active) begin
      next_q.link_stat = LS_FAIL;
    end
    next_q.rcv_gate  = gate;
    next_q.xmit_gate = gate;

    // receive side
    next_q.sync1 = {i_receive_only_pair, i_bidirectional_pair_a, i_bidirectional_pair_b};
    next_q.sync2 = q.sync1;
    if (!gate || !i_rx_carrier) begin
      next_q.rx_kind = RX_IDLE;
    end else if (i_rx_aligned) begin
      next_q.rx_kind = RX_DATA;
    end else begin
      next_q.rx_kind = RX_PREAMBLE;
    end
    next_q.rx_sym   = (next_q.rx_kind == RX_DATA) ? q.sync2 : 6'h00;
    // cleared with carrier; a detection in the same cycle still sets it
    next_q.rx_error = gate && (i_rx_err_detect || (q.rx_error && i_rx_carrier));
    // transmit side, one vector per clock
    if (eff_data) begin
      next_q.tx_active = 1'b1;
      next_q.collided  = q.collided || i_pma_carrier;
      next_q.tx_pair   = i_tx_sym_pair;
      if (next_q.collided) begin
        next_q.bi_a  = `PMALT_SYM_ZERO;
        next_q.bi_b  = `PMALT_SYM_ZERO;
        next_q.bi_oe = 1'b0;
      end else begin
        next_q.bi_a  = i_tx_sym_bi_a;
        next_q.bi_b  = i_tx_sym_bi_b;
        next_q.bi_oe = 1'b1;
      end
      // reload so the pattern after the packet opens with silence
      next_q.idl     = IDL_SILENT;
      next_q.sil_cnt = q.sil_load;
    end else begin
      next_q.tx_active = 1'b0;
      next_q.collided  = q.collided && i_tx_data;
      next_q.bi_a      = `PMALT_SYM_ZERO;
      next_q.bi_b      = `PMALT_SYM_ZERO;
      next_q.bi_oe     = 1'b0;
      unique case (q.idl)
        IDL_SILENT: begin
          next_q.tx_pair = `PMALT_SYM_ZERO;
          if (q.sil_cnt <= `PMALT_CNT_W'(1)) begin
            next_q.idl = IDL_PULSE_NEG;
          end else begin
            next_q.sil_cnt = q.sil_cnt - `PMALT_CNT_W'(1);
          end
        end
        IDL_PULSE_NEG: begin
          next_q.tx_pair = `PMALT_SYM_NEG;
          next_q.idl     = IDL_PULSE_POS;
        end
        IDL_PULSE_POS: begin
          next_q.tx_pair = `PMALT_SYM_POS;
          next_q.idl     = IDL_SILENT;
          next_q.sil_cnt = q.sil_load;
        end
        default: begin
          next_q.tx_pair = `PMALT_SYM_ZERO;
          next_q.idl     = IDL_SILENT;
          next_q.sil_cnt = q.sil_load;
        end
      endcase
    end

    // reset branch of every machine; power-down parks the block the same way
    if (pma_reset || q.power_down) begin
      next_q.link_ctrl = LC_ENABLE;
      next_q.link_stat = LS_FAIL;
      next_q.rcv_gate  = 1'b0;
      next_q.xmit_gate = 1'b0;
      next_q.rx_kind   = RX_IDLE;
      next_q.rx_sym    = 6'h00;
      next_q.rx_error  = 1'b0;
      next_q.collided  = 1'b0;
      next_q.tx_active = 1'b0;
      next_q.idl       = IDL_SILENT;
      next_q.sil_cnt   = q.sil_load;
      next_q.tx_pair   = `PMALT_SYM_ZERO;
      next_q.bi_a      = `PMALT_SYM_ZERO;
      next_q.bi_b      = `PMALT_SYM_ZERO;
      next_q.bi_oe     = 1'b0;
    end
    if (pma_reset) begin
      next_q.power_down = `PMALT_RST_PDN;
      next_q.sil_load   = SIL_RESET;
    end
  end

  // ==========================================================================
  // state register
  // reset count starts loaded so operation waits for the internal reset to finish
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q            <= '0;
      q.rst_cnt    <= `PMALT_RST_CYCLES;
      q.power_down <= `PMALT_RST_PDN;
      q.link_ctrl  <= LC_ENABLE;
      q.link_stat  <= LS_FAIL;
      q.rx_kind    <= RX_IDLE;
      q.idl        <= IDL_SILENT;
      q.sil_cnt    <= SIL_RESET;
      q.sil_load   <= SIL_RESET;
      q.tx_pair    <= `PMALT_SYM_ZERO;
      q.bi_a       <= `PMALT_SYM_ZERO;
      q.bi_b       <= `PMALT_SYM_ZERO;
      q.hrdata     <= `PMALT_RST_RDATA;
    end else if (i_clk_en) begin
      q <= next_q;
    end
  end

  // ==========================================================================
  // outputs
  assign o_hrdata                  = q.hrdata;
  assign o_hreadyout               = 1'b1;
  assign o_hresp                   = 1'b0;
  assign o_link_status             = q.link_stat;
  assign o_li_hold_reset           = pma_reset || (q.link_ctrl == LC_DISABLE);
  assign o_li_block_pass           = (q.link_ctrl == LC_SCAN);
  assign o_rcv_gate                = q.rcv_gate;
  assign o_xmit_gate               = q.xmit_gate;
  assign o_pma_reset               = pma_reset;
  assign o_rx_kind                 = q.rx_kind;
  assign o_rx_sym_pair             = q.rx_sym[5:4];
  assign o_rx_sym_bi_a             = q.rx_sym[3:2];
  assign o_rx_sym_bi_b             = q.rx_sym[1:0];
  assign o_rx_error                = q.rx_error;
  assign o_transmit_only_pair      = q.tx_pair;
  assign o_bidirectional_pair_a    = q.bi_a;
  assign o_bidirectional_pair_a_oe = q.bi_oe;
  assign o_bidirectional_pair_b    = q.bi_b;
  assign o_bidirectional_pair_b_oe = q.bi_oe;

  // ==========================================================================
  // assertions
  a_scan_gates_shut: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_clk_en && q.link_ctrl == LC_SCAN) |-> o_li_block_pass ##1 (!q.rcv_gate && !q.xmit_gate))
    else $error("gates open during scan");
  a_disable_reports: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_clk_en && q.link_ctrl == LC_DISABLE) |=> (q.link_stat == LS_FAIL) && !q.xmit_gate)
    else $error("disable did not report fail");
  a_enable_opens: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_clk_en && active && q.link_ctrl == LC_ENABLE && i_li_pass)
      |=> q.rcv_gate && q.xmit_gate && (q.link_stat == LS_OK))
    else $error("enable with pass left gates shut");
  a_reset_to_enable: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_clk_en && pma_reset) |=> (q.link_ctrl == LC_ENABLE) && !q.xmit_gate)
    else $error("reset did not restore enable");
  a_pulse_order: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_clk_en && q.idl == IDL_PULSE_NEG && !eff_data && active)
      |=> (q.tx_pair == `PMALT_SYM_NEG) && (q.idl == IDL_PULSE_POS))
    else $error("link pulse did not start negative");
  a_collide_silence: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_clk_en && active && eff_data && (i_pma_carrier || q.collided))
      |=> !q.bi_oe && (q.bi_a == `PMALT_SYM_ZERO) && (q.bi_b == `PMALT_SYM_ZERO))
    else $error("bidirectional pairs driven in collision");
  a_data_passes: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_clk_en && active && eff_data && !i_pma_carrier && !q.collided)
      |=> (q.tx_pair == $past(i_tx_sym_pair)) && (q.bi_a == $past(i_tx_sym_bi_a)) && q.bi_oe)
    else $error("data vector not driven");
  a_gate_forces_idle: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_clk_en && !gate) |=> !q.tx_active && !q.bi_oe)
    else $error("data sent with transmit gate shut");
  a_silence_first: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_clk_en && q.tx_active && !eff_data) |=> (q.idl == IDL_SILENT)
      && (q.tx_pair == `PMALT_SYM_ZERO))
    else $error("idle after packet began with a pulse");
  a_silence_range: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (q.sil_load >= SIL_LO) && (q.sil_load <= SIL_HI) && (q.sil_cnt <= SIL_HI))
    else $error("silence length out of range");
  a_rx_shut_idle: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_clk_en && !gate) |=> (q.rx_kind == RX_IDLE) && !q.rx_error)
    else $error("receive reported while gate shut");

endmodule : pmalt_core

`default_nettype wire

// ==== logic/pmalt_params.svh ====
// constants of the link-control and transmit attachment block
// assumes a 25 MHz symbol clock that is also the register clock
`ifndef PMALT_PARAMS_SVH
`define PMALT_PARAMS_SVH

// register byte offsets
`define PMALT_ADDR_CTRL   8'h00
`define PMALT_ADDR_STAT   8'h04
`define PMALT_ADDR_IDLE   8'h08

// control register fields
`define PMALT_CTRL_SRST   0
`define PMALT_CTRL_PDN    1

// status register fields
`define PMALT_STAT_LINK   0
`define PMALT_STAT_CTL    2
`define PMALT_STAT_RCV    4
`define PMALT_STAT_XMIT   5
`define PMALT_STAT_RST    6
`define PMALT_STAT_RXERR  7
`define PMALT_STAT_COLL   8

// reset values
`define PMALT_RST_PDN     1'b0
`define PMALT_RST_RDATA   32'h0000_0000

// ternary symbol codes, two-bit signed
`define PMALT_SYM_POS     2'h1
`define PMALT_SYM_ZERO    2'h0
`define PMALT_SYM_NEG     2'h3

// timing
`define PMALT_CLK_KHZ     25000
`define PMALT_SILENCE_US  1200
`define PMALT_SIL_TOL_US  600
`define PMALT_RST_CYCLES  3'h4
`define PMALT_CNT_W       16

`endif

// ==== logic/pmalt_pkg.sv ====
// types shared by the link-control and transmit attachment block
// assumes pmalt_params.svh sits on the include path
`include "pmalt_params.svh"

package pmalt_pkg;

  typedef logic signed [1:0] pmalt_sym_t;

  typedef enum logic [1:0] {LC_SCAN, LC_DISABLE, LC_ENABLE} pmalt_link_ctrl_t;
  typedef enum logic [1:0] {LS_FAIL, LS_READY, LS_OK} pmalt_link_stat_t;
  typedef enum logic [1:0] {RX_IDLE, RX_PREAMBLE, RX_DATA} pmalt_rx_kind_t;
  typedef enum logic [1:0] {IDL_SILENT, IDL_PULSE_NEG, IDL_PULSE_POS} pmalt_idle_t;

  typedef struct packed {
    logic [2:0]               rst_cnt;
    logic                     power_down;
    pmalt_link_ctrl_t         link_ctrl;
    pmalt_link_stat_t         link_stat;
    logic                     rcv_gate;
    logic                     xmit_gate;
    logic [5:0]               sync1;
    logic [5:0]               sync2;
    pmalt_rx_kind_t           rx_kind;
    logic [5:0]               rx_sym;
    logic                     rx_error;
    logic                     collided;
    logic                     tx_active;
    pmalt_idle_t              idl;
    logic [`PMALT_CNT_W-1:0]  sil_cnt;
    logic [`PMALT_CNT_W-1:0]  sil_load;
    pmalt_sym_t               tx_pair;
    pmalt_sym_t               bi_a;
    pmalt_sym_t               bi_b;
    logic                     bi_oe;
    logic                     wr_pend;
    logic [7:0]               wr_addr;
    logic [31:0]              hrdata;
  } pmalt_state_t;

endpackage : pmalt_pkg

// ==== test/pmalt_core_tb.sv ====
// bench for the link-control and transmit attachment core
// assumes the bench plays bus master, negotiator, client and link logic
`timescale 1ns/1ps
`default_nettype none
`include "pmalt_params.svh"
module pmalt_core_tb
  import pmalt_pkg::*;
;
  typedef struct packed {int due; pmalt_sym_t p, a, b;} pmalt_tb_exp_t;
  logic clk = 1'b0, rst_n, hsel, hwrite, hready, hresp, lvalid, pass, seen;
  logic hold, blk, rg, xg, prst, txd, car, rxc, rxa, rxe, rerr, aoe, boe;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, r;
  pmalt_link_ctrl_t lreq;
  pmalt_link_stat_t lstat;
  pmalt_rx_kind_t rk;
  pmalt_sym_t sp, sa, sb, rsp, rsa, rsb, tp, ta, tb_, rp, pa, pb, wa, wb_, p, a, b;
  pmalt_tb_exp_t q[$], e;
  int cyc = 0, failures = 0, n_tests = 0;
  pmalt_link_ctrl_t lc[5] = '{LC_SCAN, LC_SCAN, LC_DISABLE, LC_ENABLE, pmalt_link_ctrl_t'(2'h3)};
  logic [5:0] le[5] = '{6'h14, 6'h04, 6'h08, 6'h23, 6'h23};
  int wv[3] = '{5, 40, 12}, ev[3] = '{10, 30, 12};
  logic hready_o;
  assign hready = 1'b1 & hready_o;
  // far side drives the bidirectional wires only while the core is silent
  assign wa = aoe ? ta : pa;
  assign wb_ = boe ? tb_ : pb;
  always #20 clk = ~clk;
  pmalt_core #(.SILENCE_CYCLES(20), .SILENCE_MIN(10), .SILENCE_MAX(30)) pmalt_core_i (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_clk_en(1'b1), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready_o), .o_hresp(hresp),
    .i_link_req_valid(lvalid), .i_link_req(lreq), .o_link_status(lstat),
    .i_li_pass(pass), .i_li_pulses_seen(seen), .o_li_hold_reset(hold),
    .o_li_block_pass(blk), .o_rcv_gate(rg), .o_xmit_gate(xg), .o_pma_reset(prst),
    .i_tx_data(txd), .i_tx_sym_pair(sp), .i_tx_sym_bi_a(sa), .i_tx_sym_bi_b(sb),
    .i_pma_carrier(car), .i_rx_carrier(rxc), .i_rx_aligned(rxa), .i_rx_err_detect(rxe),
    .o_rx_kind(rk), .o_rx_sym_pair(rsp), .o_rx_sym_bi_a(rsa), .o_rx_sym_bi_b(rsb),
    .o_rx_error(rerr), .o_transmit_only_pair(tp), .i_receive_only_pair(rp),
    .o_bidirectional_pair_a(ta), .o_bidirectional_pair_a_oe(aoe),
    .i_bidirectional_pair_a(wa), .o_bidirectional_pair_b(tb_),
    .o_bidirectional_pair_b_oe(boe), .i_bidirectional_pair_b(wb_));
  pmalt_remote_phy pmalt_remote_phy_i (.i_clk_sys(clk), .i_send(rxc), .o_pair(rp),
    .o_bi_a(pa), .o_bi_b(pb));
  // =====================================
  // shared tasks
  task automatic final_report();
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic ahb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, ad};
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask : ahb
  task automatic link(input pmalt_link_ctrl_t c);
    @(posedge clk);
    lvalid <= 1'b1;
    lreq   <= c;
    @(posedge clk);
    lvalid <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : link
  task automatic step(input logic d, c, input pmalt_sym_t p, a, b, ep, ea, eb);
    @(posedge clk);
    txd <= d;
    car <= c;
    sp  <= p;
    sa  <= a;
    sb  <= b;
    q.push_back('{cyc + 2, ep, ea, eb});
  endtask : step
  function automatic pmalt_sym_t sym(input int unsigned v);
    return (v % 3 == 2) ? `PMALT_SYM_NEG : pmalt_sym_t'(v % 3);
  endfunction : sym
  // =====================================
  // pin monitor and hang guard
  always @(posedge clk) begin
    if (q.size() > 0 && q[0].due == cyc) begin
      e = q.pop_front();
      chk({tp, ta, tb_}, {e.p, e.a, e.b});
    end
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      final_report();
    end
  end
  // =====================================
  // scenarios
  initial begin
    {rst_n, hsel, hwrite, lvalid, seen, txd, car, rxc, rxa, rxe} = '0;
    {htrans, haddr, hwdata, sp, sa, sb} = '0;
    pass = 1'b1;
    lreq = LC_ENABLE;
    void'($urandom(32'hd395));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk(prst, 1);
    repeat (4) @(posedge clk);
    #1 chk(prst, 0);
    ahb(0, `PMALT_ADDR_STAT, 0);
    chk(r[5:0], 6'h3A);
    ahb(0, 8'h0C, 0);
    chk(r, 0);
    chk(hresp, 0);
    for (int i = 0; i < 5; i++) begin
      seen <= (i != 1);
      link(lc[i]);
      chk({lstat, hold, blk, rg, xg}, le[i]);
    end
    // power-down from scan must come back in enable
    link(LC_SCAN);
    ahb(1, `PMALT_ADDR_CTRL, 32'h0000_0002);
    ahb(0, `PMALT_ADDR_CTRL, 0);
    chk(r, 32'h0000_0002);
    ahb(1, `PMALT_ADDR_CTRL, 0);
    ahb(0, `PMALT_ADDR_STAT, 0);
    chk(r[5:0], 6'h3A);
    link(LC_DISABLE);
    @(posedge clk);
    txd <= 1'b1;
    sa  <= `PMALT_SYM_POS;
    repeat (3) @(posedge clk);
    #1 chk({ta, aoe, boe}, 0);
    ahb(1, `PMALT_ADDR_CTRL, 1);
    txd <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(prst, 1);
    repeat (6) @(posedge clk);
    ahb(0, `PMALT_ADDR_STAT, 0);
    chk(r[3:2], LC_ENABLE);
    for (int i = 0; i < 3; i++) begin
      ahb(1, `PMALT_ADDR_IDLE, wv[i]);
      ahb(0, `PMALT_ADDR_IDLE, 0);
      chk(r, ev[i]);
    end
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 8; i++) begin
        p = sym($urandom);
        a = sym($urandom);
        b = sym($urandom);
        // carrier drops again at the last vector, shut-off must persist
        step(1, i inside {5, 6}, p, a, b, p, i > 4 ? 2'h0 : a, i > 4 ? 2'h0 : b);
      end
      // silence of 12 from the register, then the pulse; second gap is cut after its negative half
      for (int i = 0; i < (k == 0 ? 16 : k == 1 ? 13 : 0); i++)
        step(0, 0, sym($urandom), 1, 1, i == 12 ? `PMALT_SYM_NEG :
             i == 13 ? `PMALT_SYM_POS : 2'h0, 0, 0);
    end
    step(0, 0, 0, 0, 0, 0, 0, 0);
    repeat (3) @(posedge clk);
    rxc <= 1'b1;
    repeat (5) @(posedge clk);
    #1 chk(rk, RX_PREAMBLE);
    rxa <= 1'b1;
    rxe <= 1'b1;
    @(posedge clk);
    rxe <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk({rk, rsp, rsa, rsb, rerr},
           {RX_DATA, `PMALT_SYM_POS, `PMALT_SYM_NEG, `PMALT_SYM_ZERO, 1'b1});
    {rxc, rxa, pass} <= 3'h0;
    repeat (4) @(posedge clk);
    #1 chk({rk, rerr, rg, xg}, {RX_IDLE, 3'h0});
    final_report();
  end
endmodule : pmalt_core_tb
`default_nettype wire

// ==== test/pmalt_remote_phy.sv ====
// remote end of the medium: drives the three receive pins
// assumes the bench resolves the shared bidirectional wires
`timescale 1ns/1ps
`default_nettype none
`include "pmalt_params.svh"
module pmalt_remote_phy
  import pmalt_pkg::*;
(
  input  wire logic i_clk_sys,
  input  wire logic i_send,
  output pmalt_sym_t o_pair,
  output pmalt_sym_t o_bi_a,
  output pmalt_sym_t o_bi_b
);
  logic [1:0] wob = 2'h0;
  // =====================================
  // line drive
  // a quiet line wanders so a stale level never looks like data
  always @(posedge i_clk_sys) begin
    wob    <= wob + 2'h1;
    o_pair <= i_send ? `PMALT_SYM_POS : wob;
    o_bi_a <= i_send ? `PMALT_SYM_NEG : ~wob;
    o_bi_b <= i_send ? `PMALT_SYM_ZERO : wob;
  end
endmodule : pmalt_remote_phy
`default_nettype wire
